// File: verilog/zcd_ctrl.sv
// Contract
// - Without inversion the level bit is 1 above the threshold, 0 below.
// - With inversion set, level bit and detector output are complemented.
// - Edge detection for the crossing flag works on the inverted output.
// - Comparison only starts once the enable bit is 1.
// - With pin drive enable set, the detector output is routed to the pin.
// - A crossing matching the edge select sets the crossing flag.
// - The request stays high while the edge select is not none and the flag is set.
// - A two-bit edge select picks rise, fall, both or none.
// - With standby keep-alive set, everything keeps working in standby.
`timescale 1ns/1ps
module zcd_ctrl (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  // control bits
  input  wire logic             i_enable,
  input  wire logic             i_invert,
  input  wire logic             i_pin_drive_enable,
  input  wire logic             i_standby_keep_alive,
  input  wire logic             i_standby,
  input  wire zcd_pkg::zcd_edge_t i_edge_select,
  input  wire logic             i_flag_clear,
  // analog comparator
  input  wire logic             i_comparator,
  // status and outputs
  output logic                  o_level,
  output logic                  o_crossing_flag,
  output logic                  o_irq,
  output logic                  o_event,
  output logic                  o_pin_out,
  output logic                  o_pin_oe,
  output logic                  o_analog_enable
);
  import zcd_pkg::*;

  zcd_sync_if sif ();
  logic sync_cmp;
  logic active;
  logic lvl_r, lvl_nxt;
  logic prev_r, prev_nxt;
  logic valid_r, valid_nxt;
  logic flag_r, flag_nxt;
  logic irq_r, irq_nxt;
  logic pin_r, pin_nxt;
  logic oe_r, oe_nxt;
  logic aen_r, aen_nxt;
  logic rise, fall, hit;

  assign sif.async_in = i_comparator;
  zcd_sync #(.STAGES(ZCD_SYNC_LEN)) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .sif        (sif)
  );
  assign sync_cmp = sif.sync_out;

  // standby stops the block unless kept alive
  assign active = i_enable & (~i_standby | i_standby_keep_alive);

  always_comb begin
    aen_nxt  = active;
    lvl_nxt  = active ? (sync_cmp ^ i_invert) : ZCD_RST_BIT;
    // xor above applies inversion
    prev_nxt = lvl_nxt;
    // first active cycle has no prior level, so no false edge
    valid_nxt = active;
    rise = valid_r & active & ~prev_r & lvl_nxt;
    fall = valid_r & active & prev_r & ~lvl_nxt;
    case (i_edge_select)
      ZCD_EDGE_OFF:  hit = 1'b0;
      ZCD_EDGE_RISE: hit = rise;
      ZCD_EDGE_FALL: hit = fall;
      ZCD_EDGE_BOTH: hit = rise | fall;
      default:       hit = 1'b0;
    endcase
    // set wins over clear
    flag_nxt = hit | (flag_r & ~i_flag_clear);
    irq_nxt  = flag_nxt & (i_edge_select != ZCD_EDGE_OFF);
    oe_nxt   = active & i_pin_drive_enable;
    pin_nxt  = oe_nxt & lvl_nxt;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lvl_r   <= ZCD_RST_BIT;
      prev_r  <= ZCD_RST_BIT;
      valid_r <= ZCD_RST_BIT;
      flag_r  <= ZCD_RST_BIT;
      irq_r   <= ZCD_RST_BIT;
      pin_r   <= ZCD_RST_BIT;
      oe_r    <= ZCD_RST_BIT;
      aen_r   <= ZCD_RST_BIT;
    end else begin
      lvl_r   <= lvl_nxt;
      prev_r  <= prev_nxt;
      valid_r <= valid_nxt;
      flag_r  <= flag_nxt;
      irq_r   <= irq_nxt;
      pin_r   <= pin_nxt;
      oe_r    <= oe_nxt;
      aen_r   <= aen_nxt;
    end
  end

  assign o_level         = lvl_r;
  assign o_crossing_flag = flag_r;
  assign o_irq           = irq_r;
  assign o_event         = lvl_r;
  assign o_pin_out       = pin_r;
  assign o_pin_oe        = oe_r;
  assign o_analog_enable = aen_r;

  property p_level;
    @(posedge i_core_clk) disable iff (i_rst)
      active |=> (o_level == ($past(sync_cmp) ^ $past(i_invert)));
  endproperty
  a_level: assert property (p_level) else $error("level wrong");

  property p_off;
    @(posedge i_core_clk) disable iff (i_rst)
      !active |=> !o_level && !o_pin_oe && !o_analog_enable;
  endproperty
  a_off: assert property (p_off) else $error("not idle when off");

  property p_pin;
    @(posedge i_core_clk) disable iff (i_rst)
      (active && i_pin_drive_enable) |=> o_pin_oe && (o_pin_out == o_level);
  endproperty
  a_pin: assert property (p_pin) else $error("pin not driven");

  property p_rise;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_RISE && rise) |=> o_crossing_flag;
  endproperty
  a_rise: assert property (p_rise) else $error("rise lost");

  property p_nofall;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_RISE && !o_crossing_flag && !rise)
        |=> !o_crossing_flag;
  endproperty
  a_nofall: assert property (p_nofall) else $error("bad flag");

  property p_irq;
    @(posedge i_core_clk) disable iff (i_rst)
      (o_crossing_flag && !i_flag_clear && i_edge_select != ZCD_EDGE_OFF)
        |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");

  property p_hold;
    @(posedge i_core_clk) disable iff (i_rst)
      (o_crossing_flag && !i_flag_clear) |=> o_crossing_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");

  property p_sync;
    @(posedge i_core_clk) disable iff (i_rst)
      (active && !$past(i_rst) && !$past(i_rst, 2))
        |=> o_level == ($past(i_comparator, 3) ^ $past(i_invert));
  endproperty
  a_sync: assert property (p_sync) else $error("sync path");

  property p_stby;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_enable && i_standby && i_standby_keep_alive) |=> o_analog_enable;
  endproperty
  a_stby: assert property (p_stby) else $error("standby off");

  property p_inv;
    @(posedge i_core_clk) disable iff (i_rst)
      (active && i_invert) |=> (o_level == !$past(sync_cmp));
  endproperty
  a_inv: assert property (p_inv) else $error("inversion lost");

  property p_rise_inv;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_RISE && i_invert && active
        && o_analog_enable && !o_level && !sync_cmp) |=> o_crossing_flag;
  endproperty
  a_rise_inv: assert property (p_rise_inv) else $error("inv edge");

  property p_first;
    @(posedge i_core_clk) disable iff (i_rst)
      (!o_analog_enable && !o_crossing_flag) |=> !o_crossing_flag;
  endproperty
  a_first: assert property (p_first) else $error("early edge");

  property p_pin_off;
    @(posedge i_core_clk) disable iff (i_rst)
      !(active && i_pin_drive_enable) |=> !o_pin_oe && !o_pin_out;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin on");

  property p_clear;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_flag_clear && i_edge_select == ZCD_EDGE_OFF) |=> !o_crossing_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag stuck");

  property p_irq_off;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_OFF) |=> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq on");

  property p_fall;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_FALL && fall) |=> o_crossing_flag;
  endproperty
  a_fall: assert property (p_fall) else $error("fall lost");

  property p_both;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_BOTH && (rise || fall)) |=> o_crossing_flag;
  endproperty
  a_both: assert property (p_both) else $error("edge lost");

  property p_none;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_edge_select == ZCD_EDGE_OFF && !o_crossing_flag)
        |=> !o_crossing_flag;
  endproperty
  a_none: assert property (p_none) else $error("flag while off");

  property p_stby_off;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_standby && !i_standby_keep_alive) |=> !o_analog_enable && !o_level;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby on");
endmodule

// File: verilog/zcd_pkg.sv
package zcd_pkg;
  // edge select encodings
  localparam logic [1:0] ZCD_EDGE_OFF  = 2'h0;
  localparam logic [1:0] ZCD_EDGE_RISE = 2'h1;
  localparam logic [1:0] ZCD_EDGE_FALL = 2'h2;
  localparam logic [1:0] ZCD_EDGE_BOTH = 2'h3;
  // reset values
  localparam logic       ZCD_RST_BIT   = 1'h0;
  localparam logic [1:0] ZCD_RST_EDGE  = 2'h0;
  // synchroniser depth
  localparam int         ZCD_SYNC_LEN  = 2;
  typedef logic [1:0] zcd_edge_t;
endpackage

// File: verilog/zcd_sync_if.sv
`timescale 1ns/1ps
interface zcd_sync_if;
  logic async_in;
  logic sync_out;
  modport src (output async_in, input sync_out);
  modport dst (input async_in, output sync_out);
endinterface

// File: verilog/zcd_sync.sv
`timescale 1ns/1ps
module zcd_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  // crossing
  zcd_sync_if.dst   sif
);
  import zcd_pkg::*;
  logic [STAGES-1:0] stage_r;
  logic [STAGES-1:0] stage_nxt;

  if (STAGES < 2) begin : g_bad_stages
    $error("zcd_sync needs at least two stages");
  end

  always_comb begin
    stage_nxt = {stage_r[STAGES-2:0], sif.async_in};
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign sif.sync_out = stage_r[STAGES-1];
endmodule

// File: tb/zcd_src_model.sv
`timescale 1ns/1ps
module zcd_src_model (
  // wanted side of the threshold
  input  wire logic i_above,
  // comparator result, not tied to the clock
  output logic      o_comparator
);
  // sense pin analog, no pulls, digital buffer off
  // lag breaks any phase tie with the core clock
  initial o_comparator = 1'h0;
  always @(i_above) o_comparator <= #3 i_above;
endmodule

// File: tb/zcd_ctrl_tb.sv
`timescale 1ns/1ps
module zcd_ctrl_tb;
  import zcd_pkg::*;
  logic clk = 0, rst = 1, en = 0, inv = 0, pde = 0, ska = 0, sby = 0;
  logic clr = 0, above = 0, cmp, lvl, flg, irq, evt, pin, oe, aen;
  logic e_lvl, e_flg, e_irq, e_oe, e_aen, p_act, act, cur, hit;
  logic sq[$];
  logic [31:0] r;
  zcd_edge_t sel = ZCD_EDGE_OFF;
  int err_count = 0, check_count = 0;
  zcd_src_model u_src (.i_above(above), .o_comparator(cmp));
  zcd_ctrl u_dut (.i_core_clk(clk), .i_rst(rst), .i_enable(en),
    .i_invert(inv), .i_pin_drive_enable(pde), .i_standby_keep_alive(ska),
    .i_standby(sby), .i_edge_select(sel), .i_flag_clear(clr),
    .i_comparator(cmp), .o_level(lvl), .o_crossing_flag(flg),
    .o_irq(irq), .o_event(evt), .o_pin_out(pin), .o_pin_oe(oe),
    .o_analog_enable(aen));
  initial forever #5 clk = ~clk;
  // reference model, sync queue then level and edge logic
  always @(posedge clk) begin
    if (rst) begin
      sq.delete();
      repeat (ZCD_SYNC_LEN) sq.push_back(1'b0);
      {e_lvl, e_flg, e_irq, e_oe, e_aen, p_act} = 6'h00;
    end else begin
      act = en & (~sby | ska);
      cur = sq.pop_front() ^ inv;
      hit = act & p_act & (cur != e_lvl) & ((sel == ZCD_EDGE_BOTH) |
          ((sel == ZCD_EDGE_RISE) & cur) | ((sel == ZCD_EDGE_FALL) & ~cur));
      e_flg = hit | (e_flg & ~clr);
      e_irq = e_flg & (sel != ZCD_EDGE_OFF);
      e_lvl = act & cur;
      e_oe = act & pde;
      e_aen = act;
      p_act = act;
      sq.push_back(cmp);
    end
  end
  task automatic chk(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: output differs from model", $time);
    end
  endtask
  // outputs settled mid-cycle; skip the first two negedges, at 10 and 20 ns
  always @(negedge clk) begin
    if ($time > 20) begin
      chk(lvl, e_lvl);
      chk(flg, e_flg);
      chk(irq, e_irq);
      chk(evt, e_lvl);
      chk(pin, e_lvl & e_oe);
      chk(oe, e_oe);
      chk(aen, e_aen);
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(31834));
    repeat (10) @(posedge clk);
    #1 rst = 0;
    // pin drive first, then enable
    pde = 1;
    en = 1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1 r = $urandom;
      if (r[1:0] == 2'h0) above = ~above;
      // flags left over from before enable are dropped when enable rises
      clr = (r[4:2] == 3'h0) | ((r[31:26] != 6'h00) & ~en);
      if (r[9:5] == 5'h00) sel = r[11:10];
      if (r[16:12] == 5'h00) inv = ~inv;
      if (r[20:17] == 4'h0) sby = ~sby;
      if (r[24:21] == 4'h0) ska = ~ska;
      if (r[28:25] == 4'h0) pde = ~pde;
      en = (r[31:26] != 6'h00);
      rst = (i >= 1500) && (i < 1504); // mid-run reset
    end
    tally_and_finish;
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule
